// File: serial_tx_pkg.sv
// shared constants for the serial video transmit control block
// assumes a 100 MHz bit clock, ten bit clocks per write-clock period
package serial_tx_pkg;

  // ----------------------------------------
  // character timing
  // ----------------------------------------
  localparam int         BITS_PER_CHAR = 10;          // bits in one transmission character
  localparam int         RP_LOW_PCT    = 60;          // read strobe low share, percent
  localparam logic [3:0] LAST_BIT      = 4'(BITS_PER_CHAR - 1);
  localparam logic [3:0] RP_LOW_BITS   = 4'(BITS_PER_CHAR * RP_LOW_PCT / 100);

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] CTRL_OFFSET     = 4'h0;      // mode select
  localparam logic [3:0] STATUS_OFFSET   = 4'h4;      // last character, disparity, self-test
  localparam int         CTRL_MODE_LSB   = 0;
  localparam int         STATUS_CHAR_LSB = 0;
  localparam int         STATUS_RD_BIT   = 10;
  localparam int         STATUS_BIST_BIT = 11;

  // encoder mode, mirrors the three-level strap
  typedef enum logic [1:0]
  {
    MODE_ENCODED = 2'b00,
    MODE_BYPASS  = 2'b01,
    MODE_TEST    = 2'b10
  } enc_mode_t;
  localparam enc_mode_t CTRL_MODE_RESET = MODE_ENCODED;

  // ----------------------------------------
  // special characters
  // ----------------------------------------
  localparam logic [7:0] FILL_BYTE      = 8'hbc;      // K28.5 filler
  localparam logic [7:0] ALT_BYTE       = 8'h4a;      // D10.2, alternating one-zero
  localparam logic [9:0] VIOLATION_CHAR = 10'h3f0;    // never a legal code
  localparam logic [7:0] BIST_SEED      = 8'h01;      // pattern start value
  localparam int         BIST_LOOP_LEN  = 255;        // bytes per self-test loop

endpackage

// File: tx_char_if.sv
// signals between the transmit control and its encoder and pattern generator
// assumes all three modules share one clock
`timescale 1ns/1ns
interface tx_char_if;
  logic       enc_load;      // take the character, advance disparity
  logic       enc_k;         // encode as control code
  logic [7:0] enc_byte;      // byte to encode
  logic [9:0] enc_char;      // encoded character, a first at bit 9
  logic       enc_rd;        // running disparity, high when positive
  logic       bist_step;     // advance the test sequence
  logic       bist_restart;  // back to the sequence start
  logic [7:0] bist_byte;     // current test byte
  logic       bist_last;     // current byte ends the loop

  modport ctrl (output enc_load, enc_k, enc_byte, bist_step, bist_restart,
                input enc_char, enc_rd, bist_byte, bist_last);
  modport enc (input enc_load, enc_k, enc_byte, output enc_char, enc_rd);
  modport gen (input bist_step, bist_restart, output bist_byte, bist_last);
endinterface

// File: tx_char_encoder.sv
// 8b/10b character encoder with running disparity
// assumes the loader pulses enc_load once per character
`timescale 1ns/1ns
module tx_char_encoder
  import serial_tx_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  tx_char_if.enc    ch
);

  typedef struct packed
  {
    logic rd_pos;  // running disparity positive
  } enc_state_t;

  enc_state_t st;       // registered state
  enc_state_t next_st;  // next state

  // 5b/6b codes for negative disparity, abcdei
  function automatic logic [5:0] code6(input logic [4:0] x);
    logic [5:0] c;
    case (x)
      5'd0: c = 6'b100111;  5'd1: c = 6'b011101;  5'd2: c = 6'b101101;
      5'd3: c = 6'b110001;  5'd4: c = 6'b110101;  5'd5: c = 6'b101001;
      5'd6: c = 6'b011001;  5'd7: c = 6'b111000;  5'd8: c = 6'b111001;
      5'd9: c = 6'b100101;  5'd10: c = 6'b010101; 5'd11: c = 6'b110100;
      5'd12: c = 6'b001101; 5'd13: c = 6'b101100; 5'd14: c = 6'b011100;
      5'd15: c = 6'b010111; 5'd16: c = 6'b011011; 5'd17: c = 6'b100011;
      5'd18: c = 6'b010011; 5'd19: c = 6'b110010; 5'd20: c = 6'b001011;
      5'd21: c = 6'b101010; 5'd22: c = 6'b011010; 5'd23: c = 6'b111010;
      5'd24: c = 6'b110011; 5'd25: c = 6'b100110; 5'd26: c = 6'b010110;
      5'd27: c = 6'b110110; 5'd28: c = 6'b001110; 5'd29: c = 6'b101110;
      5'd30: c = 6'b011110; default: c = 6'b101011;
    endcase
    return c;
  endfunction

  // 3b/4b codes for negative disparity, fghj
  function automatic logic [3:0] code4(input logic [2:0] y);
    logic [3:0] c;
    case (y)
      3'd0: c = 4'b1011; 3'd1: c = 4'b1001; 3'd2: c = 4'b0101; 3'd3: c = 4'b1100;
      3'd4: c = 4'b1101; 3'd5: c = 4'b1010; 3'd6: c = 4'b0110; default: c = 4'b1110;
    endcase
    return c;
  endfunction

  // ----------------------------------------
  // encode
  // ----------------------------------------
  // codes, disparity after each sub-block, alternate .7 selection
  always_comb
  begin
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] t6;
    logic [3:0] t4;
    logic       k28;
    logic       unb6;
    logic       unb4;
    logic       rd1;
    logic       a7;
    logic       inv4;
    x       = ch.enc_byte[4:0];
    y       = ch.enc_byte[7:5];
    k28     = ch.enc_k && (x == 5'd28);
    t6      = k28 ? 6'b001111 : code6(x);
    unb6    = ($countones(t6) != 3);
    rd1     = st.rd_pos ^ unb6;
    // alternate .7 avoids a run of five in the data alphabet
    a7      = (y == 3'd7) && (ch.enc_k
              || (!rd1 && (x == 5'd17 || x == 5'd18 || x == 5'd20))
              || (rd1 && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
    t4      = a7 ? 4'b0111 : code4(y);
    unb4    = (y == 3'd0) || (y == 3'd4) || (y == 3'd7);
    // K28 flips its balanced tails against the 6b sub-block
    inv4    = (rd1 && (unb4 || y == 3'd3)) || (k28 && !rd1 && !unb4 && y != 3'd3);
    ch.enc_char = {(st.rd_pos && (unb6 || x == 5'd7)) ? ~t6 : t6, inv4 ? ~t4 : t4};
    next_st = st;
    if (ch.enc_load)
    begin
      next_st.rd_pos = rd1 ^ unb4;
    end
  end

  assign ch.enc_rd = st.rd_pos;

  // state register, disparity starts negative
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      st <= '0;
    else
      st <= next_st;
  end

endmodule

// File: tx_self_test_gen.sv
// self-test byte sequence advanced on each step, looping every LOOP_LEN bytes
// assumes steps come once per write-clock period
`timescale 1ns/1ns
module tx_self_test_gen
  import serial_tx_pkg::*;
#(
  parameter int LOOP_LEN = BIST_LOOP_LEN  // bytes per loop
)
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  tx_char_if.gen    ch
);

  typedef struct packed
  {
    logic [7:0] lfsr;  // pattern register
    logic [7:0] cnt;   // position in the loop
  } gen_state_t;

  gen_state_t st;       // registered state
  gen_state_t next_st;  // next state

  assign ch.bist_byte = st.lfsr;
  assign ch.bist_last = (st.cnt == 8'(LOOP_LEN - 1));

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  // restart wins over a step, the loop end reseeds so the receiver can lock
  always_comb
  begin
    next_st = st;
    if (ch.bist_restart || (ch.bist_step && ch.bist_last))
    begin
      next_st.lfsr = BIST_SEED;
      next_st.cnt  = '0;
    end
    else if (ch.bist_step)
    begin
      next_st.lfsr = {st.lfsr[6:0], st.lfsr[7] ^ st.lfsr[5] ^ st.lfsr[4] ^ st.lfsr[3]};
      next_st.cnt  = st.cnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      st      <= '0;
      st.lfsr <= BIST_SEED;
    end
    else
      st <= next_st;
  end

endmodule

// File: serial_video_tx_control.sv
// transmit control of a serial video link: capture, encode, serialize
// assumes the write clock pin runs at one tenth of i_clk and is asynchronous
//
// Overview of operation
// - enable low: capture this edge's byte
// - next enable low: capture following edge's byte
// - both enables high: send filler, ignore inputs
// - filler is the K28.5 code
// - control select high picks control alphabet
// - force violation sends violation, overrides test
// - write clock paces bits and captures bytes
// - optical off low: all pairs carry data
// - optical off high: first two pairs zero
// - loopback pair always carries the stream
// - mode encoded: 8b/10b encode every byte
// - mode bypass: ten raw bits to shifter
// - mode test: bit clock from output pins
// - self-test, enables high: alternating one-zero
// - self-test, an enable low: repeating sequence
// - sequence free-runs; violation restarts it (the code steps it only on sent self-test bytes)
// - self-test enable sampled like data
// - read strobe low sixty percent per byte
// - strobe follows enable, width set internally
// - self-test: strobe low on loop's last byte
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
module serial_video_tx_control
  import serial_tx_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_byte_write_clock,
  input  wire logic [7:0]  i_parallel_in_byte,
  input  wire logic        i_byte_enable_n,
  input  wire logic        i_next_byte_enable_n,
  input  wire logic        i_control_char_select,
  input  wire logic        i_force_violation,
  input  wire logic        i_self_test_enable_n,
  input  wire logic        i_optical_tx_off,
  input  wire logic        i_serial_line_primary_p,
  input  wire logic        i_serial_line_secondary_p,
  output logic             o_serial_line_primary_p,
  output logic             o_serial_line_primary_n,
  output logic             o_serial_line_primary_oe,
  output logic             o_serial_line_secondary_p,
  output logic             o_serial_line_secondary_n,
  output logic             o_serial_line_secondary_oe,
  output logic             o_serial_line_loopback_p,
  output logic             o_serial_line_loopback_n,
  output logic             o_fifo_read_strobe_n,
  input  wire logic [3:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed
  {
    logic [16:0] sync1;      // pin synchroniser, first stage
    logic [16:0] sync2;      // pin synchroniser, second stage
    logic        wclk_prev;  // write clock, previous sample
    logic        tclk_prev;  // test bit clock, previous sample
    logic        pend_next;  // next-edge capture requested
    enc_mode_t   mode;       // encoder mode
    logic [9:0]  shreg;      // serializer
    logic [3:0]  bitcnt;     // bit position in character
    logic        rp_armed;   // read strobe due this byte
    logic        bist_on;    // self-test in force this byte
    logic [9:0]  last_char;  // last loaded character
    logic        waitreq;    // bus wait
    logic [31:0] rdata;      // bus read data
    logic        pri_p;      // primary pair, true side
    logic        pri_n;      // primary pair, complement
    logic        pri_oe;     // primary true side driven
    logic        sec_p;      // secondary pair, true side
    logic        sec_n;      // secondary pair, complement
    logic        sec_oe;     // secondary true side driven
    logic        lb_p;       // loopback pair, true side
    logic        lb_n;       // loopback pair, complement
    logic        rp_n;       // read strobe
  } ctl_state_t;

  ctl_state_t st;       // registered state
  ctl_state_t next_st;  // next state

  tx_char_if ch ();     // link to encoder and pattern generator

  // synchronised pin views
  logic       s_wclk;   // write clock
  logic [7:0] s_byte;   // parallel byte
  logic       s_ena;    // byte enable, low active
  logic       s_enn;    // next byte enable, low active
  logic       s_csel;   // control select
  logic       s_fv;     // force violation
  logic       s_ste;    // self-test enable, low active
  logic       s_optical_tx_off;   // optical off
  logic       s_pri;    // primary true pin, test clock plus
  logic       s_sec;    // secondary true pin, test clock minus

  assign {s_wclk, s_byte, s_ena, s_enn, s_csel, s_fv, s_ste, s_optical_tx_off, s_pri, s_sec} = st.sync2;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  tx_char_encoder u_encoder
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .ch      (ch)
  );

  tx_self_test_gen #(.LOOP_LEN(BIST_LOOP_LEN)) u_self_test
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .ch      (ch)
  );

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  // byte selection, serializer, line drivers, read strobe, bus slave
  always_comb
  begin
    logic       wclk_rise;
    logic       tclk;
    logic       bit_adv;
    logic       is_test;
    logic       is_bypass;
    logic       bist_now;
    logic       both_high;
    logic       take;
    logic [9:0] char;
    logic [7:0] rev;
    logic       sbit;
    next_st       = st;
    // pins pass two flops before anything reads them
    next_st.sync1 = {i_byte_write_clock, i_parallel_in_byte, i_byte_enable_n,
                     i_next_byte_enable_n, i_control_char_select, i_force_violation,
                     i_self_test_enable_n, i_optical_tx_off, i_serial_line_primary_p,
                     i_serial_line_secondary_p};
    next_st.sync2 = st.sync1;

    wclk_rise         = s_wclk & ~st.wclk_prev;
    next_st.wclk_prev = s_wclk;
    is_test           = (st.mode == MODE_TEST);
    is_bypass         = (st.mode == MODE_BYPASS);
    // test mode: bit clock arrives differentially on the primary and secondary true pins
    tclk              = s_pri & ~s_sec;
    next_st.tclk_prev = tclk;
    bit_adv           = is_test ? (tclk & ~st.tclk_prev) : 1'b1;
    bist_now          = ~s_ste;
    both_high         = s_ena & s_enn;
    take              = ~s_ena | st.pend_next;

    ch.enc_load     = 1'b0;
    ch.enc_k        = 1'b0;
    ch.enc_byte     = s_byte;
    ch.bist_step    = 1'b0;
    ch.bist_restart = 1'b0;
    char            = ch.enc_char;
    rev = {<<{s_byte}};

    if (wclk_rise)
    begin
      next_st.pend_next = ~s_enn;
      if (is_bypass)
      begin
        // select and violation pins become the outer raw bits
        char = {s_csel, rev, s_fv};
      end
      else if (s_fv)
      begin
        char            = VIOLATION_CHAR;
        ch.bist_restart = bist_now;
      end
      else if (bist_now)
      begin
        ch.enc_load = 1'b1;
        if (both_high)
          ch.enc_byte = ALT_BYTE;
        else
        begin
          ch.enc_byte  = ch.bist_byte;
          ch.bist_step = 1'b1;
        end
      end
      else if (take)
      begin
        ch.enc_load = 1'b1;
        ch.enc_k    = s_csel;
      end
      else
      begin
        // gap between user bytes
        ch.enc_load = 1'b1;
        ch.enc_k    = 1'b1;
        ch.enc_byte = FILL_BYTE;
      end
      next_st.shreg     = char;
      next_st.bitcnt    = '0;
      next_st.last_char = char;
      next_st.bist_on   = bist_now;
      // self-test: strobe only once per loop
      if (bist_now)
        next_st.rp_armed = ~both_high & ~s_fv & ~is_bypass & ch.bist_last;
      else
        next_st.rp_armed = ~s_ena;
    end
    else if (bit_adv)
    begin
      // a first, one bit per bit clock
      next_st.shreg = {st.shreg[8:0], 1'b0};
      if (st.bitcnt != LAST_BIT)
        next_st.bitcnt = st.bitcnt + 4'h1;
    end

    // line drivers
    sbit              = st.shreg[9];
    next_st.pri_p     = sbit & ~s_optical_tx_off;
    next_st.pri_n     = ~(sbit & ~s_optical_tx_off);
    next_st.sec_p     = sbit & ~s_optical_tx_off;
    next_st.sec_n     = ~(sbit & ~s_optical_tx_off);
    next_st.pri_oe    = ~is_test;
    next_st.sec_oe    = ~is_test;
    next_st.lb_p      = sbit;
    next_st.lb_n      = ~sbit;
    // width counted in bit clocks, not taken from the write clock duty
    next_st.rp_n      = ~(next_st.rp_armed & (next_st.bitcnt < RP_LOW_BITS));

    // bus slave: one wait cycle, then a single answer cycle
    next_st.waitreq = 1'b1;
    if (st.waitreq & (i_read | i_write))
    begin
      next_st.waitreq = 1'b0;
      unique case (i_address)
        CTRL_OFFSET:
          next_st.rdata = 32'(st.mode) << CTRL_MODE_LSB;
        STATUS_OFFSET:
          next_st.rdata = (32'(st.last_char) << STATUS_CHAR_LSB)
                          | (32'(ch.enc_rd) << STATUS_RD_BIT)
                          | (32'(st.bist_on) << STATUS_BIST_BIT);
        default:
          next_st.rdata = 32'h0;
      endcase
    end
    // write takes effect at the edge where wait is low
    if (~st.waitreq & i_write & (i_address == CTRL_OFFSET))
    begin
      unique case (i_writedata[CTRL_MODE_LSB +: 2])
        2'b01:   next_st.mode = MODE_BYPASS;
        2'b10:   next_st.mode = MODE_TEST;
        default: next_st.mode = MODE_ENCODED;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      st         <= '0;
      st.mode    <= CTRL_MODE_RESET;
      st.waitreq <= 1'b1;
      st.pri_n   <= 1'b1;
      st.sec_n   <= 1'b1;
      st.lb_n    <= 1'b1;
      st.pri_oe  <= 1'b1;
      st.sec_oe  <= 1'b1;
      st.rp_n    <= 1'b1;
    end
    else
      st <= next_st;
  end

  // outputs straight from the state register
  assign o_serial_line_primary_p    = st.pri_p;
  assign o_serial_line_primary_n    = st.pri_n;
  assign o_serial_line_primary_oe   = st.pri_oe;
  assign o_serial_line_secondary_p  = st.sec_p;
  assign o_serial_line_secondary_n  = st.sec_n;
  assign o_serial_line_secondary_oe = st.sec_oe;
  assign o_serial_line_loopback_p   = st.lb_p;
  assign o_serial_line_loopback_n   = st.lb_n;
  assign o_fifo_read_strobe_n       = st.rp_n;
  assign o_readdata                 = st.rdata;
  assign o_waitrequest              = st.waitreq;

endmodule

// File: tx_ctrl_props.sv
// port-level checks of the serial transmit control
// assumes one clock domain and the active-high async reset
`timescale 1ns/1ns
module tx_ctrl_props
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic i_optical_tx_off,
  input wire logic o_waitrequest,
  input wire logic o_fifo_read_strobe_n,
  input wire logic o_serial_line_primary_p,
  input wire logic o_serial_line_primary_n,
  input wire logic o_serial_line_primary_oe,
  input wire logic o_serial_line_secondary_p,
  input wire logic o_serial_line_secondary_n,
  input wire logic o_serial_line_loopback_p,
  input wire logic o_serial_line_loopback_n
);
  // ----------------------------------------
  // run counters, saturate at 7
  // ----------------------------------------
  logic [2:0] off_run;  // cycles with optical off high
  logic [2:0] on_run;   // cycles with optical off low

  // pin is synchronised first, so the gate lags by a few cycles
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      off_run <= 3'h0;
      on_run  <= 3'h0;
    end
    else
    begin
      off_run <= !i_optical_tx_off ? 3'h0 : off_run + 3'(off_run != 3'h7);
      on_run  <= i_optical_tx_off ? 3'h0 : on_run + 3'(on_run != 3'h7);
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  bus_answer_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("no answer one cycle after request");
  bus_gap_a: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("answer held longer than one cycle");
  bus_idle_a: assert property (!i_read && !i_write && o_waitrequest |=> o_waitrequest)
    else $error("answer without request");
  strobe_width_a: assert property ($fell(o_fifo_read_strobe_n) |->
    (!o_fifo_read_strobe_n)[*6] ##1 o_fifo_read_strobe_n) else $error("strobe width wrong");
  strobe_rate_a: assert property ($fell(o_fifo_read_strobe_n) |=>
    (!$fell(o_fifo_read_strobe_n))[*8]) else $error("strobe faster than byte rate");
  optical_dark_a: assert property (off_run == 3'h7 |->
    !o_serial_line_primary_p && o_serial_line_primary_n &&
    !o_serial_line_secondary_p && o_serial_line_secondary_n) else $error("pairs not dark");
  line_follow_a: assert property (on_run == 3'h7 && o_serial_line_primary_oe |->
    o_serial_line_primary_p == o_serial_line_loopback_p &&
    o_serial_line_secondary_p == o_serial_line_loopback_p) else $error("pairs differ");
  loop_pair_a: assert property (o_serial_line_loopback_n == !o_serial_line_loopback_p)
    else $error("loopback pair not complementary");
endmodule

bind serial_video_tx_control tx_ctrl_props i_tx_ctrl_props (.i_clk(i_clk), .i_reset(i_reset),
  .i_read(i_read), .i_write(i_write), .i_optical_tx_off(i_optical_tx_off),
  .o_waitrequest(o_waitrequest), .o_fifo_read_strobe_n(o_fifo_read_strobe_n),
  .o_serial_line_primary_p(o_serial_line_primary_p),
  .o_serial_line_primary_n(o_serial_line_primary_n),
  .o_serial_line_primary_oe(o_serial_line_primary_oe),
  .o_serial_line_secondary_p(o_serial_line_secondary_p),
  .o_serial_line_secondary_n(o_serial_line_secondary_n),
  .o_serial_line_loopback_p(o_serial_line_loopback_p),
  .o_serial_line_loopback_n(o_serial_line_loopback_n));

// File: fifo_host_model.sv
// behavioural byte source standing in for an async fifo
// assumes i_clk is ten times the byte rate
`timescale 1ns/1ns
module fifo_host_model
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_run,
  input  wire logic i_read_strobe_n,
  output logic      o_write_clock,
  output logic [7:0] o_byte,
  output logic      o_byte_enable_n
);
  logic [3:0] phase;     // position within the byte period
  logic       strobe_q;  // strobe one cycle ago

  // byte clock and fifo advance; the byte moves on the strobe's fall,
  // well away from the write-clock edge that captures it
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      phase    <= 4'h0;
      strobe_q <= 1'b1;
      o_byte   <= 8'h35;
      o_write_clock <= 1'b0;
    end
    else
    begin
      phase         <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
      o_write_clock <= phase < 4'h5;
      strobe_q      <= i_read_strobe_n;
      if (strobe_q && !i_read_strobe_n)
        o_byte <= o_byte + 8'h01;
    end
  end

  // the enable is held at a steady level, the other one stays high
  always_comb o_byte_enable_n = !i_run;
endmodule

// File: tb_serial_video_tx_control.sv
// self-checking bench of the serial transmit control
// assumes the fifo model, the checker bind and the package
`timescale 1ns/1ns
module tb_serial_video_tx_control
  import serial_tx_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        run = 1'b0;           // fifo model streams bytes
  logic        next_en_n = 1'b1;
  logic        sel = 1'b0;
  logic        viol = 1'b0;
  logic        st_n = 1'b1;          // self-test enable, low active
  logic        off = 1'b0;           // optical off
  logic        pin_a = 1'b0;         // test-mode bit clock
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        wclk, en_n, pa_p, pa_n, pa_oe, pb_p, pb_n, pb_oe, lp_p, lp_n, strobe_n, wreq;
  logic [7:0]  din;
  logic [31:0] rdata, q;
  logic [9:0]  e;                    // expected raw character
  logic        strobe_q = 1'b1;
  int          n_fail = 0, n_tests = 0, cycles = 0, falls = 0, i;

  always #5 i_clk = ~i_clk;

  serial_video_tx_control i_serial_video_tx_control (.i_clk(i_clk), .i_reset(i_reset),
    .i_byte_write_clock(wclk), .i_parallel_in_byte(din), .i_byte_enable_n(en_n),
    .i_next_byte_enable_n(next_en_n), .i_control_char_select(sel), .i_force_violation(viol),
    .i_self_test_enable_n(st_n), .i_optical_tx_off(off), .i_serial_line_primary_p(pin_a),
    .i_serial_line_secondary_p(!pin_a), .o_serial_line_primary_p(pa_p),
    .o_serial_line_primary_n(pa_n), .o_serial_line_primary_oe(pa_oe),
    .o_serial_line_secondary_p(pb_p), .o_serial_line_secondary_n(pb_n),
    .o_serial_line_secondary_oe(pb_oe), .o_serial_line_loopback_p(lp_p),
    .o_serial_line_loopback_n(lp_n), .o_fifo_read_strobe_n(strobe_n), .i_address(adr),
    .i_read(rd), .i_write(wr), .i_writedata(wdata), .o_readdata(rdata),
    .o_waitrequest(wreq));

  fifo_host_model i_fifo_host_model (.i_clk(i_clk), .i_reset(i_reset), .i_run(run),
    .i_read_strobe_n(strobe_n), .o_write_clock(wclk), .o_byte(din), .o_byte_enable_n(en_n));

  // ----------------------------------------
  // closing, compares, bus access
  // ----------------------------------------
  task report_and_stop;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_count(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      n_fail++;
      $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  // hold the request until waitrequest is seen low at an edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdata <= d;
    do @(posedge i_clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // four byte periods, enough for the pin synchronisers
  task settle;
    repeat (40) @(posedge i_clk);
  endtask

  // counted on falling edges so the tally never races the edge
  task count_falls(input int n, input int exp);
    @(negedge i_clk);
    falls = 0;
    repeat (n) @(negedge i_clk);
    chk_count(falls, exp);
  endtask

  // strobe fall counter and hang guard
  always @(posedge i_clk)
  begin
    cycles++;
    strobe_q <= strobe_n;
    if (strobe_q === 1'b1 && strobe_n === 1'b0)
      falls++;
    if (cycles == 12000)
    begin
      n_fail++;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    bus(1'b0, CTRL_OFFSET, 32'h0);
    chk_word(q, 32'h0);                          // mode resets to encoded
    bus(1'b1, 4'h8, 32'h3);
    bus(1'b0, 4'h8, 32'h0);
    chk_word(q, 32'h0);                          // unmapped reads zero
    chk_word({31'h0, pa_oe}, 32'h1);
    // idle link sends filler, no strobe
    settle;
    bus(1'b0, STATUS_OFFSET, 32'h0);
    chk_word({22'h0, q[9:0]}, {22'h0, q[10] ? 10'h0fa : 10'h305});
    count_falls(100, 0);
    // streaming data: one strobe per byte
    run <= 1'b1;
    settle;
    count_falls(100, 10);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    chk_word({31'h0, q[11]}, 32'h0);
    // next-byte enable loads data, not filler
    run <= 1'b0;
    next_en_n <= 1'b0;
    settle;
    bus(1'b0, STATUS_OFFSET, 32'h0);
    chk_word({31'h0, q[9:0] == 10'h0fa || q[9:0] == 10'h305}, 32'h0);
    next_en_n <= 1'b1;
    // violation overrides self-test
    st_n <= 1'b0;
    viol <= 1'b1;
    settle;
    bus(1'b0, STATUS_OFFSET, 32'h0);
    chk_word({22'h0, q[9:0]}, {22'h0, VIOLATION_CHAR});
    viol <= 1'b0;
    settle;
    bus(1'b0, STATUS_OFFSET, 32'h0);
    chk_word({20'h0, q[11], q[9:0]}, {20'h0, 1'b1, 10'h155});
    // self-test loop: one strobe per loop of bytes
    run <= 1'b1;
    settle;
    count_falls(BIST_LOOP_LEN * BITS_PER_CHAR, 1);
    run <= 1'b0;
    st_n <= 1'b1;
    // bypass: raw bits, select first, violation last
    bus(1'b1, CTRL_OFFSET, 32'h1);
    for (i = 0; i < 2; i++)
    begin
      sel <= i[0];
      viol <= !i[0];
      settle;
      e[9] = i[0];
      e[0] = !i[0];
      for (int b = 0; b < 8; b++)
        e[8 - b] = din[b];
      bus(1'b0, STATUS_OFFSET, 32'h0);
      chk_word({22'h0, q[9:0]}, {22'h0, e});
    end
    off <= 1'b1;
    settle;
    chk_word({30'h0, pb_p, pb_n}, 32'h1);
    off <= 1'b0;
    // factory test: first two pairs released
    bus(1'b1, CTRL_OFFSET, 32'h2);
    repeat (6) @(posedge i_clk) pin_a <= ~pin_a;
    chk_word({30'h0, pa_oe, pb_oe}, 32'h0);
    bus(1'b1, CTRL_OFFSET, 32'h0);
    report_and_stop();
  end
endmodule
